// file: uiec_pkg.sv
package uiec_pkg;
  localparam int ADDR_W = 8;
  localparam int LEN_W = 16;
  localparam int MULT_W = 6;
  localparam logic [ADDR_W-1:0] ADDR_EP_SELECT = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_EP0_COUNT = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_MAX_PAYLOAD = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_CTRL_STATUS = 8'h0c;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int CB_PKT_READY = 0;
  localparam int CB_FLUSH = 3;
  localparam int CB_UNDERRUN = 2;
  localparam int CB_SEND_STALL = 4;
  localparam int CB_SENT_STALL = 5;
  localparam int CB_TOGGLE_CLR = 6;
  localparam int CB_INCOMPLETE = 7;
  localparam int CB_DMA_MODE = 10;
  localparam int CB_FRC_TOGGLE = 11;
  localparam int CB_DMA_EN = 12;
  localparam int CB_DIR_IN = 13;
  localparam int CB_ISO = 14;
  localparam int CB_AUTO_ARM = 15;
  localparam int MP_PAYLOAD_HI = 10;
  localparam int MP_MULT_LO = 11;
  localparam int MP_HB_HI = 12;
  localparam int MP_MULT_HI = 15;
  localparam logic [15:0] MASK_SPLIT5 = 16'hffff;
  localparam logic [15:0] MASK_SPLIT2 = 16'h1fff;
  localparam logic [15:0] MASK_NOSPLIT = 16'h07ff;
  localparam logic [MULT_W-1:0] MULT_ONE = 6'h01;
  localparam logic [MULT_W-1:0] MULT_TWO = 6'h02;
  localparam logic [MULT_W-1:0] MULT_THREE = 6'h03;

  typedef struct packed {
    logic aw_full;
    logic [ADDR_W-1:0] aw_addr;
    logic w_full;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [3:0] ep_sel;
    logic [15:0] maxp;
    logic auto_arm;
    logic iso;
    logic dir_in;
    logic dma_en;
    logic frc_toggle;
    logic dma_mode;
    logic incomplete;
    logic sent_stall;
    logic send_stall;
    logic underrun;
    logic toggle;
    logic [1:0] npkts;
    logic head;
    logic [1:0][LEN_W-1:0] qlen;
    logic [LEN_W-1:0] load_cnt;
    logic [LEN_W-1:0] rem;
    logic [LEN_W-1:0] part_len;
    logic busy;
    logic resp_data;
    logic resp_zlp;
    logic resp_nak;
    logic resp_stall;
    logic [LEN_W-1:0] resp_len;
  } uiec_state_s;

  localparam uiec_state_s RESET_STATE = '0;
endpackage : uiec_pkg

// file: uiec_mult.sv
`timescale 1ns/1ps
module uiec_mult #(
  parameter int SPLIT_BITS = 5,
  parameter bit HB_ISO = 1'b1
) (
  input wire logic [15:0] maxp,
  input wire logic iso,
  input wire logic hs_mode,
  output logic [uiec_pkg::MULT_W-1:0] mult,
  output logic hb_active,
  output logic [uiec_pkg::LEN_W-1:0] full_bytes
);
  import uiec_pkg::*;
  logic [16:0] product;

  always_comb begin
    hb_active = iso && HB_ISO && (SPLIT_BITS >= 2) && hs_mode
      && (maxp[MP_MULT_LO] || maxp[MP_HB_HI]);
    mult = MULT_ONE;
    if (hb_active) begin
      mult = maxp[MP_HB_HI] ? MULT_THREE : MULT_TWO;
    end else if (!iso && SPLIT_BITS == 5) begin
      mult = {1'b0, maxp[MP_MULT_HI:MP_MULT_LO]} + MULT_ONE;
    end
    product = maxp[MP_PAYLOAD_HI:0] * mult;
    full_bytes = product[LEN_W-1:0];
  end
endmodule : uiec_mult

// file: uiec_in_endpoint.sv
`timescale 1ns/1ps
module uiec_in_endpoint #(
  parameter int SPLIT_BITS = 5,
  parameter bit HB_ISO = 1'b1,
  parameter bit SHARED_FIFO = 1'b0,
  parameter int NBUF = 2
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [uiec_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [uiec_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [6:0] ep0_rx_byte_count,
  input wire logic hs_mode,
  input wire logic load_byte,
  input wire logic in_token,
  input wire logic tx_done,
  input wire logic host_ack,
  input wire logic sof_tick,
  output logic resp_data,
  output logic [uiec_pkg::LEN_W-1:0] resp_len,
  output logic resp_zlp,
  output logic resp_nak,
  output logic resp_stall,
  output logic data_toggle,
  output logic dma_req
);
  import uiec_pkg::*;

  localparam logic [15:0] MAXP_MASK = (SPLIT_BITS == 5) ? MASK_SPLIT5 :
    (SPLIT_BITS == 2) ? MASK_SPLIT2 : MASK_NOSPLIT;
  localparam logic [1:0] NBUF_CNT = 2'(NBUF);

  uiec_state_s s;
  uiec_state_s next_s;
  logic [MULT_W-1:0] mult;
  logic hb_active;
  logic [LEN_W-1:0] full_bytes;
  logic [15:0] ctrl_word;
  logic occupied;
  logic pkt_ready;

  uiec_mult #(
    .SPLIT_BITS(SPLIT_BITS),
    .HB_ISO(HB_ISO)
  ) u_mult (
    .maxp(s.maxp),
    .iso(s.iso),
    .hs_mode(hs_mode),
    .mult(mult),
    .hb_active(hb_active),
    .full_bytes(full_bytes)
  );

  // With two buffers the ready flag drops as soon as room for a second packet exists.
  assign occupied = (s.npkts != 2'h0);
  assign pkt_ready = (s.npkts == NBUF_CNT);

  assign ctrl_word = {
    s.auto_arm,
    s.iso,
    s.dir_in,
    s.dma_en,
    s.frc_toggle,
    s.dma_mode,
    2'h0,
    s.incomplete,
    1'h0,
    s.sent_stall,
    s.send_stall,
    1'h0,
    s.underrun,
    occupied,
    pkt_ready
  };

  // Mode 0 asks for one packet at a time; mode 1 keeps asking while room remains.
  assign dma_req = s.dma_en && (s.npkts < NBUF_CNT)
    && (s.dma_mode || s.load_cnt == '0);

  assign s_axi_awready = !s.aw_full && !s.bvalid;
  assign s_axi_wready = !s.w_full && !s.bvalid;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = !s.rvalid;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign resp_data = s.resp_data;
  assign resp_len = s.resp_len;
  assign resp_zlp = s.resp_zlp;
  assign resp_nak = s.resp_nak;
  assign resp_stall = s.resp_stall;
  assign data_toggle = s.toggle;

  always_comb begin
    logic do_wr;
    logic wr_ctrl;
    logic lo;
    logic hi;
    logic commit;
    logic flush;
    logic push;
    logic pop;
    logic flush_all;
    logic tail;
    logic [LEN_W-1:0] len;
    logic [LEN_W-1:0] payload;
    logic [LEN_W-1:0] left;
    // A write acts only once address and data are both held, in whichever order they came.
    do_wr = s.aw_full && s.w_full && !s.bvalid;
    wr_ctrl = do_wr && s.aw_addr == ADDR_CTRL_STATUS;
    lo = s.w_strb[0];
    hi = s.w_strb[1];
    commit = 1'b0;
    flush = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    flush_all = 1'b0;
    tail = s.head ^ s.npkts[0];
    len = '0;
    payload = LEN_W'(s.maxp[MP_PAYLOAD_HI:0]);
    left = s.rem - s.part_len;
    next_s = s;
    next_s.resp_data = 1'b0;
    next_s.resp_zlp = 1'b0;
    next_s.resp_nak = 1'b0;
    next_s.resp_stall = 1'b0;

    if (s_axi_awvalid && s_axi_awready) begin
      next_s.aw_full = 1'b1;
      next_s.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_s.w_full = 1'b1;
      next_s.w_data = s_axi_wdata;
      next_s.w_strb = s_axi_wstrb;
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end
    if (do_wr) begin
      next_s.aw_full = 1'b0;
      next_s.w_full = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = RESP_OKAY;
      unique case (s.aw_addr)
        ADDR_EP_SELECT: begin
          if (lo) begin
            next_s.ep_sel = s.w_data[3:0];
          end
        end
        ADDR_EP0_COUNT: begin
        end
        ADDR_MAX_PAYLOAD: begin
          // Multiplier bits that the configuration lacks are never stored.
          if (lo) begin
            next_s.maxp[7:0] = s.w_data[7:0] & MAXP_MASK[7:0];
          end
          if (hi) begin
            next_s.maxp[15:8] = s.w_data[15:8] & MAXP_MASK[15:8];
          end
        end
        ADDR_CTRL_STATUS: begin
          if (hi) begin
            next_s.auto_arm = s.w_data[CB_AUTO_ARM];
            next_s.iso = s.w_data[CB_ISO];
            next_s.dir_in = s.w_data[CB_DIR_IN];
            next_s.dma_en = s.w_data[CB_DMA_EN];
            next_s.frc_toggle = s.w_data[CB_FRC_TOGGLE];
            next_s.dma_mode = s.w_data[CB_DMA_MODE];
          end
          if (lo) begin
            next_s.send_stall = s.w_data[CB_SEND_STALL];
            // A written zero clears a flag; a hardware set later in this process wins.
            if (!s.w_data[CB_INCOMPLETE]) begin
              next_s.incomplete = 1'b0;
            end
            if (!s.w_data[CB_SENT_STALL]) begin
              next_s.sent_stall = 1'b0;
            end
            if (!s.w_data[CB_UNDERRUN]) begin
              next_s.underrun = 1'b0;
            end
          end
        end
        default: begin
          next_s.bresp = RESP_SLVERR;
        end
      endcase
    end

    if (s_axi_arvalid && s_axi_arready) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = RESP_OKAY;
      unique case (s_axi_araddr)
        ADDR_EP_SELECT: next_s.rdata = {28'h0, s.ep_sel};
        ADDR_EP0_COUNT: next_s.rdata = {25'h0, ep0_rx_byte_count};
        ADDR_MAX_PAYLOAD: next_s.rdata = {16'h0, s.maxp};
        ADDR_CTRL_STATUS: next_s.rdata = {16'h0, ctrl_word};
        default: begin
          next_s.rdata = 32'h0;
          next_s.rresp = RESP_SLVERR;
        end
      endcase
    end else if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end

    if (load_byte) begin
      next_s.load_cnt = s.load_cnt + 1'b1;
    end
    // Setting ready and flush in one write aborts the packet still being loaded.
    commit = (wr_ctrl && lo && s.w_data[CB_PKT_READY])
      || (s.auto_arm && load_byte && (s.load_cnt + 1'b1) == full_bytes);
    flush = wr_ctrl && lo && s.w_data[CB_FLUSH];
    if (commit && flush) begin
      next_s.load_cnt = '0;
    end else if (commit) begin
      next_s.load_cnt = '0;
      push = (s.npkts < NBUF_CNT);
    end else if (flush) begin
      next_s.load_cnt = '0;
      pop = occupied;
    end

    // A token that arrives while a data reply awaits its end is dropped, not queued.
    if (in_token && !s.busy && (!SHARED_FIFO || s.dir_in)) begin
      if (s.send_stall && !s.iso) begin
        next_s.resp_stall = 1'b1;
        next_s.sent_stall = 1'b1;
        flush_all = 1'b1;
      end else if (!occupied) begin
        next_s.underrun = 1'b1;
        next_s.resp_zlp = s.iso;
        next_s.resp_nak = !s.iso;
      end else begin
        len = (s.rem != '0) ? s.rem : s.qlen[s.head];
        // Each token carries one slice of the buffered packet, at most one payload long.
        next_s.resp_len = (len > payload) ? payload : len;
        next_s.part_len = (len > payload) ? payload : len;
        next_s.rem = len;
        next_s.resp_data = 1'b1;
        next_s.busy = 1'b1;
      end
    end

    if (tx_done && s.busy) begin
      next_s.busy = 1'b0;
      if (host_ack || s.frc_toggle) begin
        next_s.toggle = !s.toggle;
      end
      // Bulk parts that the host did not acknowledge are resent unchanged.
      if (host_ack || s.iso) begin
        next_s.rem = left;
        if (left == '0) begin
          pop = 1'b1;
        end
      end
    end

    // A microframe boundary with slices still owed abandons that packet only.
    if (sof_tick && hb_active && s.rem != '0 && !s.busy) begin
      next_s.incomplete = 1'b1;
      next_s.rem = '0;
      pop = 1'b1;
    end

    // Popping hands the head to the other buffer and drops any slice bookkeeping.
    if (pop) begin
      next_s.head = !s.head;
      next_s.rem = '0;
    end
    if (push) begin
      next_s.qlen[tail] = s.load_cnt;
    end
    next_s.npkts = s.npkts + {1'b0, push} - {1'b0, pop};

    // A STALL empties both buffers; the loading count restarts as well.
    if (flush_all) begin
      next_s.npkts = 2'h0;
      next_s.rem = '0;
      next_s.load_cnt = '0;
    end

    // The clear comes last so that it beats a flip in the same cycle.
    if (wr_ctrl && lo && s.w_data[CB_TOGGLE_CLR]) begin
      next_s.toggle = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= RESET_STATE;
    end else begin
      s <= next_s;
    end
  end
endmodule : uiec_in_endpoint

// file: uiec_props.sv
`timescale 1ns/1ps
module uiec_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [uiec_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [6:0] ep0_rx_byte_count,
  input wire logic in_token,
  input wire logic tx_done,
  input wire logic resp_data,
  input wire logic resp_zlp,
  input wire logic resp_nak,
  input wire logic resp_stall,
  input wire logic data_toggle
);
  import uiec_pkg::*;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_reply_onehot: assert property ($onehot0({resp_data, resp_zlp, resp_nak, resp_stall}))
    else $error("two link replies at once");
  a_reply_cause: assert property ((resp_data || resp_zlp || resp_nak || resp_stall)
    |-> $past(in_token)) else $error("link reply without a token");
  a_ep0_count: assert property (s_axi_arvalid && s_axi_arready
    && s_axi_araddr == ADDR_EP0_COUNT |=> s_axi_rdata == {25'h0, $past(ep0_rx_byte_count)})
    else $error("endpoint 0 count read wrong");
  a_csr_unused: assert property (s_axi_arvalid && s_axi_arready
    && s_axi_araddr == ADDR_CTRL_STATUS |=> s_axi_rdata[9:8] == 2'h0)
    else $error("unused control bits not zero");
  // A toggle change needs a finished packet or a register write as its cause.
  a_toggle_cause: assert property ($changed(data_toggle)
    |-> $past(tx_done) || s_axi_bvalid || $past(s_axi_bvalid)) else $error("toggle moved alone");
  a_b_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  a_r_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during response");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write response missing");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response missing");
endmodule : uiec_props

// file: uiec_host_model.sv
`timescale 1ns/1ps
module uiec_host_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic tok_go,
  input wire logic ack_en,
  input wire logic [2:0] dly,
  input wire logic resp_data,
  output logic in_token,
  output logic tx_done,
  output logic host_ack,
  output logic busy
);
  logic hit;
  initial begin
    {in_token, tx_done, host_ack, busy, hit} = '0;
    forever begin
      @(posedge aclk);
      if (tok_go === 1'b1 && aresetn === 1'b1) begin
        busy <= 1'b1;
        in_token <= 1'b1;
        hit = 1'b0;
        @(posedge aclk);
        in_token <= 1'b0;
        repeat (2) begin
          #1;
          hit = hit | (resp_data === 1'b1);
          @(posedge aclk);
        end
        if (hit) begin
          repeat (dly) @(posedge aclk);
          tx_done <= 1'b1;
          host_ack <= ack_en;
          @(posedge aclk);
          tx_done <= 1'b0;
        end
        busy <= 1'b0;
      end
      // Flipping the idle acknowledge keeps a stale value from passing for a real one.
      host_ack <= ~host_ack;
    end
  end
endmodule : uiec_host_model

// file: testbench.sv
`timescale 1ns/1ps
module testbench;
  import uiec_pkg::*;
  localparam logic [7:0] CS = ADDR_CTRL_STATUS;
  localparam logic [7:0] MP = ADDR_MAX_PAYLOAD;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic hs_mode, load_byte, in_token, tx_done, host_ack, sof_tick, resp_data, resp_zlp;
  logic resp_nak, resp_stall, data_toggle, dma_req, tok_go, ack_en, busy;
  logic [2:0] s_axi_awprot, s_axi_arprot, dly;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [6:0] ep0_rx_byte_count;
  logic [15:0] resp_len;
  int errors = 0, cmp_count = 0, n_data = 0, n_nak = 0, n_zlp = 0, n_stall = 0, n_len = 0;
  int seed, b, k, l0;
  uiec_in_endpoint i_uiec_in_endpoint (.*);
  uiec_host_model i_uiec_host_model (.*);
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    n_len += (resp_data === 1'b1) ? int'(resp_len) : 0;
    n_data += (resp_data === 1'b1);
    n_nak += (resp_nak === 1'b1);
    n_zlp += (resp_zlp === 1'b1);
    n_stall += (resp_stall === 1'b1);
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("FAIL %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  function automatic int exp_slices(input int len, input int pay);
    return (len + pay - 1) / pay;
  endfunction : exp_slices
  function automatic int exp_toggle(input int start, input int flips);
    return (start + flips) % 2;
  endfunction : exp_toggle
  task automatic wrap_up;
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : wrap_up
  task automatic tmo;
    errors++;
    $display("FAIL %0t wait ran out", $time);
    wrap_up();
  endtask : tmo
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    int i;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'($random(seed)), d};
    s_axi_wstrb <= 4'h3;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (i == 40) tmo();
  endtask : wr
  task automatic rd(input logic [7:0] a);
    int i;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    rd_d = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (i == 40) tmo();
  endtask : rd
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(rd_d, e);
    chk({30'h0, rsp}, {30'h0, RESP_OKAY});
  endtask : rc
  task automatic load(input int n);
    repeat (n) begin
      load_byte <= 1'b1;
      @(posedge aclk);
    end
    load_byte <= 1'b0;
  endtask : load
  // The wait on busy also covers a slow host, so no fixed reply delay is assumed.
  task automatic tok;
    int i;
    dly <= 3'($random(seed));
    tok_go <= 1'b1;
    @(posedge aclk);
    tok_go <= 1'b0;
    for (i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (busy === 1'b0) break;
    end
    if (i == 40) tmo();
  endtask : tok
  initial begin
    seed = 57;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {hs_mode, load_byte, sof_tick, tok_go, s_axi_awprot, s_axi_arprot, dly} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, ep0_rx_byte_count} = '0;
    ack_en = 1'b1;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rc(CS, 32'h0);
    rc(MP, 32'h0);
    chk({31'h0, dma_req}, 32'h0);
    rd(8'h40);
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
    wr(8'h40, 16'hffff);
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
    for (k = 0; k < 3; k++) begin
      b = $random(seed);
      ep0_rx_byte_count <= 7'(b);
      rc(ADDR_EP0_COUNT, {25'h0, 7'(b)});
    end
    wr(ADDR_EP_SELECT, 16'(b[3:0]));
    rc(ADDR_EP_SELECT, {28'h0, b[3:0]});
    wr(MP, 16'hffff);
    rc(MP, 32'hffff);
    wr(CS, 16'hff10);
    rc(CS, 32'hfc10);
    chk({31'h0, dma_req}, 32'h1);
    wr(CS, 16'h0400);
    chk({31'h0, dma_req}, 32'h0);
    wr(CS, 16'h0000);
    wr(CS, 16'h1000);
    chk({31'h0, dma_req}, 32'h1);
    load(1);
    @(posedge aclk);
    chk({31'h0, dma_req}, 32'h0);
    wr(CS, 16'h1001);
    chk({31'h0, dma_req}, 32'h1);
    wr(CS, 16'h0008);
    b = n_nak;
    tok();
    chk(n_nak, b + 1);
    rc(CS, 32'h4);
    wr(CS, 16'h0010);
    b = n_stall;
    tok();
    chk(n_stall, b + 1);
    rc(CS, 32'h30);
    wr(CS, 16'h4010);
    b = n_zlp;
    tok();
    chk(n_zlp, b + 1);
    rc(CS, 32'h4014);
    wr(CS, 16'h0040);
    chk({31'h0, data_toggle}, 32'h0);
    wr(MP, 16'h1808);
    b = 1 + ($unsigned($random(seed)) % 4);
    load(8 * b);
    wr(CS, 16'h0001);
    rc(CS, 32'h2);
    k = n_data;
    l0 = n_len;
    repeat (b) tok();
    chk(n_data - k, exp_slices(8 * b, 8));
    chk(n_len - l0, 8 * b);
    chk({31'h0, data_toggle}, exp_toggle(0, b));
    rc(CS, 32'h0);
    ack_en <= 1'b0;
    wr(MP, 16'h0008);
    wr(CS, 16'h0008);
    load(8);
    wr(CS, 16'h0801);
    tok();
    chk({31'h0, data_toggle}, exp_toggle(b, 1));
    rc(CS, 32'h0802);
    wr(CS, 16'h0808);
    rc(CS, 32'h0800);
    b = n_nak;
    tok();
    chk(n_nak, b + 1);
    ack_en <= 1'b1;
    wr(CS, 16'h8000);
    load(8);
    rc(CS, 32'h8002);
    k = n_data;
    tok();
    chk(n_data - k, 1);
    load(5);
    rc(CS, 32'h8000);
    wr(CS, 16'h8009);
    rc(CS, 32'h8000);
    hs_mode <= 1'b1;
    wr(MP, 16'h0808);
    wr(CS, 16'h0008);
    wr(CS, 16'h4000);
    load(16);
    wr(CS, 16'h4001);
    k = n_data;
    l0 = n_len;
    repeat (2) tok();
    chk(n_data - k, exp_slices(16, 8));
    chk(n_len - l0, 16);
    rc(CS, 32'h4000);
    load(16);
    wr(CS, 16'h4001);
    tok();
    sof_tick <= 1'b1;
    @(posedge aclk);
    sof_tick <= 1'b0;
    rc(CS, 32'h4080);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rc(CS, 32'h0);
    rc(MP, 32'h0);
    wrap_up();
  end
endmodule : testbench
bind uiec_in_endpoint uiec_props i_uiec_props (.*);
